//--- hw/cwd_pkg.sv
// package for the configuration word decoder: register map, field positions, codes
// assumes a single 100 MHz clock domain and an AXI4-Lite register slave
package cwd_pkg;
  // configuration word byte addresses (not the low bits of the bus offsets below)
  localparam logic [23:0] ADDR_OSC_CFG = 24'h300000;
  localparam logic [23:0] ADDR_SUP_CFG = 24'h300002;
  // word indices for byte-addressed slave: index*4
  localparam logic [7:0] OFF_OSC_CFG = 8'h00;
  localparam logic [7:0] OFF_SUP_CFG = 8'h04;
  localparam logic [7:0] OFF_OSC_CTRL = 8'h08;
  localparam logic [7:0] OFF_REMAP_CTRL = 8'h0C;
  localparam logic [7:0] OFF_PERIPH_CTRL = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_UNLOCK = 8'h18;
  // unlock key pair for the remap lock
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  // reset value of both words (erased nonvolatile)
  localparam logic [15:0] OSC_CFG_RESET = 16'h3977;
  localparam logic [15:0] SUP_CFG_RESET = 16'hBF63;
  // oscillator word fields
  localparam int FAIL_SAFE_BIT = 13;
  localparam int SWITCH_PERMIT_BIT = 11;
  localparam int CLKOUT_BIT = 8;
  localparam int RESET_OSC_LSB = 4;
  localparam int EXT_MODE_LSB = 0;
  // supervisor word fields
  localparam int EXT_INSTR_BIT = 15;
  localparam int DEBUG_BIT = 13;
  localparam int STACK_RESET_BIT = 12;
  localparam int ONE_WAY_BIT = 11;
  localparam int ZERO_CROSS_BIT = 10;
  localparam int BROWNOUT_LSB = 6;
  localparam int LP_BROWNOUT_BIT = 5;
  localparam int POWERUP_BIT = 1;
  localparam int MCLR_BIT = 0;
  // reset oscillator codes
  localparam logic [2:0] RST_EXT = 3'h7;
  localparam logic [2:0] RST_FAST_4M = 3'h6;
  localparam logic [2:0] RST_SLOW = 3'h5;
  localparam logic [2:0] RST_SECONDARY = 3'h4;
  localparam logic [2:0] RST_EXT_PLL = 3'h2;
  localparam logic [2:0] RST_FAST_64M = 3'h0;
  // external oscillator mode codes
  localparam logic [2:0] EXT_CLOCK_HIGH = 3'h7;
  localparam logic [2:0] EXT_CLOCK_MEDIUM = 3'h6;
  localparam logic [2:0] EXT_CLOCK_LOW = 3'h5;
  localparam logic [2:0] EXT_OFF = 3'h4;
  localparam logic [2:0] CRYSTAL_HIGH_SPEED = 3'h2;
  localparam logic [2:0] CRYSTAL_MEDIUM = 3'h1;
  localparam logic [2:0] CRYSTAL_32K = 3'h0;
  // fast oscillator frequency and divider codes
  localparam logic [3:0] FREQ_4M = 4'h2;
  localparam logic [3:0] FREQ_64M = 4'h8;
  localparam logic [3:0] DIV_4 = 4'h2;
  localparam logic [3:0] DIV_1 = 4'h0;
  // brownout modes
  localparam logic [1:0] BOR_ALWAYS = 2'h3;
  localparam logic [1:0] BOR_AWAKE = 2'h2;
  localparam logic [1:0] BOR_SOFT = 2'h1;
  // clock-out divide
  localparam logic [1:0] CLKOUT_DIV_LAST = 2'h3;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    CWD_LOAD = 2'b00,
    CWD_RUN = 2'b01
  } cwd_state_t;
endpackage

//--- hw/cwd_osc_decode.sv
// oscillator word decoder: reset source and external mode to control levels
// assumes its inputs are stable latched configuration values
`timescale 1ns/1ps
module cwd_osc_decode (
  input wire logic [2:0] reset_osc_select, // reset oscillator field
  input wire logic [2:0] ext_osc_mode, // external oscillator mode field
  output logic [2:0] boot_osc, // current selection after reset
  output logic [3:0] boot_freq, // fast oscillator frequency code
  output logic [3:0] boot_div, // divider code
  output logic boot_pll, // 4x pll on
  output logic crystal_mode, // one of the three crystal modes
  output logic ext_enable, // external oscillator runs
  output logic reserved_code // reserved code seen
);
  // decode of the reset source, plus the reserved mode code flag
  always_comb begin
    boot_osc = reset_osc_select;
    boot_freq = cwd_pkg::FREQ_4M;
    boot_div = cwd_pkg::DIV_4;
    boot_pll = 1'b0;
    reserved_code = 1'b0;
    case (reset_osc_select)
      cwd_pkg::RST_FAST_64M: begin
        boot_osc = cwd_pkg::RST_FAST_4M;
        boot_freq = cwd_pkg::FREQ_64M;
        boot_div = cwd_pkg::DIV_1;
      end
      cwd_pkg::RST_EXT_PLL: boot_pll = 1'b1;
      cwd_pkg::RST_EXT, cwd_pkg::RST_FAST_4M, cwd_pkg::RST_SLOW,
      cwd_pkg::RST_SECONDARY: boot_osc = reset_osc_select;
      default: reserved_code = 1'b1;
    endcase
    if (ext_osc_mode == 3'h3) begin
      reserved_code = 1'b1;
    end
  end
  // crystal and external clock classes
  assign crystal_mode = (ext_osc_mode == cwd_pkg::CRYSTAL_HIGH_SPEED) ||
                        (ext_osc_mode == cwd_pkg::CRYSTAL_MEDIUM) ||
                        (ext_osc_mode == cwd_pkg::CRYSTAL_32K);
  assign ext_enable = (ext_osc_mode != cwd_pkg::EXT_OFF) && (ext_osc_mode != 3'h3);
endmodule

//--- hw/cwd_top.sv
// configuration word decoder: latches two words at reset, drives decoded controls
// assumes AXI4-Lite master on clk, synchronous active-high reset, nvm words stable
// Functional notes
// - fail-safe monitor follows word1 bit 13
// - permit bit gates new oscillator writes
// - crystal modes ignore the clock-out bit
// - clock-out zero drives clock/4 on pin
// - reset field loads current oscillator select
// - reset field codes pick boot clock
// - code 000 gives 64 MHz, selects 110
// - external clock mode field decodes speeds
// - crystal mode codes, 011 reserved
// - word2 bit 15 zero enables extended set
// - debugger enabled when bit 13 zero
// - stack fault resets when bit set
// - one-way lock sets once only
// - otherwise lock takes written bit 0 after unlock sequence
// - zero-cross forced on when bit zero
// - brownout mode field with software bit
// - low-power brownout enabled when bit zero
// - power-up timer enabled when bit zero
// - master clear pin per low-voltage programming
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module cwd_top (
  input wire logic clk, // 100 MHz clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [15:0] nvm_osc_word, // oscillator word from storage
  input wire logic [15:0] nvm_sup_word, // supervisor word from storage
  input wire logic low_voltage_program, // programming mode strap
  input wire logic stack_fault, // stack overflow or underflow pulse
  input wire logic sleep_mode, // core asleep
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  output logic fail_safe_monitor_en, // clock monitor on
  output logic [2:0] current_osc_select, // running oscillator
  output logic [2:0] new_osc_select, // requested oscillator
  output logic [3:0] new_divider_select, // requested divider
  output logic [3:0] fast_osc_freq_select, // fast oscillator frequency
  output logic pll_en, // 4x pll on
  output logic [2:0] ext_osc_mode, // external oscillator mode
  output logic ext_osc_en, // external oscillator on
  output logic osc_output_pin, // clock-out pin value
  output logic osc_output_pin_oe, // clock-out pin driven
  output logic extended_instr_en, // extended instruction set on
  output logic debugger_en, // background debugger on
  output logic stack_reset_req, // reset request from stack fault
  output logic pin_remap_locked, // remap registers locked
  output logic zero_cross_en, // zero-cross detector on
  output logic brownout_en, // brownout reset active
  output logic low_power_brownout_en, // low-power brownout on
  output logic powerup_timer_en, // power-up timer on
  output logic master_clear_en // pin acts as master clear
);
  cwd_pkg::cwd_state_t state, next_state;
  logic [15:0] osc_word, next_osc_word, sup_word, next_sup_word;
  logic [2:0] next_cur, next_new;
  logic [3:0] next_div, next_freq;
  logic next_pll, next_locked, next_sw_bor, next_zc_sw, next_zc_mod_off;
  logic sw_bor, zc_sw, zc_mod_off, lock_used, next_lock_used;
  logic [1:0] unlock_step, next_unlock_step;
  logic [1:0] clk_div, next_clk_div;
  logic [2:0] boot_osc;
  logic [3:0] boot_freq, boot_div;
  logic boot_pll, crystal_mode, ext_enable, reserved_code;
  logic lvp_s1, lvp_s2, fault_s1, fault_s2, sleep_s1, sleep_s2;
  // bus state
  logic aw_hold, w_hold, next_aw_hold, next_w_hold;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic do_write;
  // decode of the latched oscillator word
  cwd_osc_decode u_dec (
    .reset_osc_select(osc_word[cwd_pkg::RESET_OSC_LSB +: 3]),
    .ext_osc_mode(osc_word[cwd_pkg::EXT_MODE_LSB +: 3]),
    .boot_osc(boot_osc),
    .boot_freq(boot_freq),
    .boot_div(boot_div),
    .boot_pll(boot_pll),
    .crystal_mode(crystal_mode),
    .ext_enable(ext_enable),
    .reserved_code(reserved_code)
  );

  // two-flop synchronisers for outside levels
  always_ff @(posedge clk) begin
    lvp_s1 <= low_voltage_program;
    lvp_s2 <= lvp_s1;
    fault_s1 <= stack_fault;
    fault_s2 <= fault_s1;
    sleep_s1 <= sleep_mode;
    sleep_s2 <= sleep_s1;
  end

  assign do_write = aw_hold && w_hold && !s_axi_bvalid;

  // next values for configuration and control state
  always_comb begin
    next_state = state;
    next_osc_word = osc_word;
    next_sup_word = sup_word;
    next_cur = current_osc_select;
    next_new = new_osc_select;
    next_div = new_divider_select;
    next_freq = fast_osc_freq_select;
    next_pll = pll_en;
    next_locked = pin_remap_locked;
    next_lock_used = lock_used;
    next_unlock_step = unlock_step;
    next_sw_bor = sw_bor;
    next_zc_sw = zc_sw;
    next_zc_mod_off = zc_mod_off;
    next_clk_div = clk_div + 2'h1;
    case (state)
      cwd_pkg::CWD_LOAD: begin
        next_osc_word = nvm_osc_word;
        next_sup_word = nvm_sup_word;
        next_state = cwd_pkg::CWD_RUN;
      end
      cwd_pkg::CWD_RUN: begin
        if (do_write && aw_addr == cwd_pkg::OFF_OSC_CTRL && w_strb[0]) begin
          if (osc_word[cwd_pkg::SWITCH_PERMIT_BIT]) begin
            next_new = w_data[2:0];
            next_div = w_data[7:4];
            next_cur = w_data[2:0];
          end
        end
        if (do_write && aw_addr == cwd_pkg::OFF_UNLOCK && w_strb[0]) begin
          if (w_data[7:0] == cwd_pkg::UNLOCK_KEY1) begin
            next_unlock_step = 2'h1;
          end else if (w_data[7:0] == cwd_pkg::UNLOCK_KEY2 && unlock_step == 2'h1) begin
            next_unlock_step = 2'h2;
          end else begin
            next_unlock_step = 2'h0;
          end
        end
        if (do_write && aw_addr == cwd_pkg::OFF_REMAP_CTRL && w_strb[0]) begin
          next_unlock_step = 2'h0;
          if (unlock_step == 2'h2) begin
            if (sup_word[cwd_pkg::ONE_WAY_BIT]) begin
              if (!lock_used && w_data[0]) begin
                next_locked = 1'b1;
                next_lock_used = 1'b1;
              end
            end else begin
              next_locked = w_data[0];
            end
          end
        end
        if (do_write && aw_addr == cwd_pkg::OFF_PERIPH_CTRL && w_strb[0]) begin
          next_sw_bor = w_data[0];
          next_zc_sw = w_data[1];
          next_zc_mod_off = w_data[2];
        end
      end
      default: next_state = cwd_pkg::CWD_LOAD;
    endcase
  end

  // control state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= cwd_pkg::CWD_LOAD;
      osc_word <= cwd_pkg::OSC_CFG_RESET;
      sup_word <= cwd_pkg::SUP_CFG_RESET;
      current_osc_select <= 3'h0;
      new_osc_select <= 3'h0;
      new_divider_select <= 4'h0;
      fast_osc_freq_select <= 4'h0;
      pll_en <= 1'b0;
      pin_remap_locked <= 1'b0;
      lock_used <= 1'b0;
      unlock_step <= 2'h0;
      sw_bor <= 1'b0;
      zc_sw <= 1'b0;
      zc_mod_off <= 1'b0;
      clk_div <= 2'h0;
    end else begin
      state <= next_state;
      osc_word <= next_osc_word;
      sup_word <= next_sup_word;
      // boot values loaded once, the cycle after the words are latched
      if (state == cwd_pkg::CWD_RUN && $past(state) == cwd_pkg::CWD_LOAD) begin
        current_osc_select <= boot_osc;
        new_osc_select <= boot_osc;
        new_divider_select <= boot_div;
        fast_osc_freq_select <= boot_freq;
        pll_en <= boot_pll;
      end else begin
        current_osc_select <= next_cur;
        new_osc_select <= next_new;
        new_divider_select <= next_div;
        fast_osc_freq_select <= next_freq;
        pll_en <= next_pll;
      end
      pin_remap_locked <= next_locked;
      lock_used <= next_lock_used;
      unlock_step <= next_unlock_step;
      sw_bor <= next_sw_bor;
      zc_sw <= next_zc_sw;
      zc_mod_off <= next_zc_mod_off;
      clk_div <= next_clk_div;
    end
  end

  // decoded control outputs, registered
  always_ff @(posedge clk) begin
    if (rst) begin
      fail_safe_monitor_en <= 1'b0;
      ext_osc_mode <= 3'h0;
      ext_osc_en <= 1'b0;
      osc_output_pin <= 1'b0;
      osc_output_pin_oe <= 1'b0;
      extended_instr_en <= 1'b0;
      debugger_en <= 1'b0;
      stack_reset_req <= 1'b0;
      zero_cross_en <= 1'b0;
      brownout_en <= 1'b0;
      low_power_brownout_en <= 1'b0;
      powerup_timer_en <= 1'b0;
      master_clear_en <= 1'b1;
    end else begin
      fail_safe_monitor_en <= osc_word[cwd_pkg::FAIL_SAFE_BIT];
      ext_osc_mode <= osc_word[cwd_pkg::EXT_MODE_LSB +: 3];
      ext_osc_en <= ext_enable;
      // clock out only outside crystal modes and with the bit low
      osc_output_pin_oe <= !crystal_mode && !osc_word[cwd_pkg::CLKOUT_BIT];
      osc_output_pin <= (clk_div == cwd_pkg::CLKOUT_DIV_LAST);
      extended_instr_en <= !sup_word[cwd_pkg::EXT_INSTR_BIT];
      debugger_en <= !sup_word[cwd_pkg::DEBUG_BIT];
      stack_reset_req <= fault_s2 && sup_word[cwd_pkg::STACK_RESET_BIT];
      // module-off bit only matters when the detector is not forced on
      zero_cross_en <= !sup_word[cwd_pkg::ZERO_CROSS_BIT] || (zc_sw && !zc_mod_off);
      case (sup_word[cwd_pkg::BROWNOUT_LSB +: 2])
        cwd_pkg::BOR_ALWAYS: brownout_en <= 1'b1;
        cwd_pkg::BOR_AWAKE: brownout_en <= !sleep_s2;
        cwd_pkg::BOR_SOFT: brownout_en <= sw_bor;
        default: brownout_en <= 1'b0;
      endcase
      low_power_brownout_en <= !sup_word[cwd_pkg::LP_BROWNOUT_BIT];
      powerup_timer_en <= !sup_word[cwd_pkg::POWERUP_BIT];
      master_clear_en <= lvp_s2 || sup_word[cwd_pkg::MCLR_BIT];
    end
  end

  // axi4-lite slave: capture address and data in either order
  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (aw_addr == cwd_pkg::OFF_OSC_CTRL || aw_addr == cwd_pkg::OFF_UNLOCK ||
                    aw_addr == cwd_pkg::OFF_REMAP_CTRL || aw_addr == cwd_pkg::OFF_PERIPH_CTRL)
                   ? cwd_pkg::RESP_OKAY : cwd_pkg::RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = cwd_pkg::RESP_OKAY;
      if (s_axi_araddr[7:0] == cwd_pkg::OFF_OSC_CFG) begin
        next_rdata = {16'h0000, osc_word};
      end else if (s_axi_araddr[7:0] == cwd_pkg::OFF_SUP_CFG) begin
        next_rdata = {16'h0000, sup_word};
      end else if (s_axi_araddr[7:0] == cwd_pkg::OFF_OSC_CTRL) begin
        next_rdata = {24'h000000, new_divider_select, 1'b0, new_osc_select};
      end else if (s_axi_araddr[7:0] == cwd_pkg::OFF_REMAP_CTRL) begin
        next_rdata = {31'h00000000, pin_remap_locked};
      end else if (s_axi_araddr[7:0] == cwd_pkg::OFF_PERIPH_CTRL) begin
        next_rdata = {29'h00000000, zc_mod_off, zc_sw, sw_bor};
      end else if (s_axi_araddr[7:0] == cwd_pkg::OFF_STATUS) begin
        next_rdata = {22'h000000, reserved_code, crystal_mode, pll_en,
                      fast_osc_freq_select, current_osc_select};
      end else begin
        next_rdata = 32'h00000000;
        next_rresp = cwd_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // axi4-lite slave registers
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
    end else begin
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      // ready only when a slot is free and no handshake this edge
      s_axi_awready <= !next_aw_hold && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !next_w_hold && !(s_axi_wvalid && s_axi_wready);
      s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // checks on the decoded outputs and the latched words
  a_fail_safe_follows: assert property (@(posedge clk) disable iff (rst)
    state == cwd_pkg::CWD_RUN |=> fail_safe_monitor_en == $past(osc_word[13]))
    else $error("fail-safe monitor does not follow its bit");
  a_switch_blocked: assert property (@(posedge clk) disable iff (rst)
    state == cwd_pkg::CWD_RUN && $past(state) == cwd_pkg::CWD_RUN && !osc_word[11]
    |=> $stable(new_osc_select))
    else $error("oscillator select changed while switching is barred");
  a_crystal_no_clkout: assert property (@(posedge clk) disable iff (rst)
    crystal_mode |=> !osc_output_pin_oe)
    else $error("clock-out driven in a crystal mode");
  a_clkout_drive: assert property (@(posedge clk) disable iff (rst)
    !crystal_mode && !osc_word[8] |=> osc_output_pin_oe)
    else $error("clock-out not driven");
  a_boot_select: assert property (@(posedge clk) disable iff (rst)
    state == cwd_pkg::CWD_LOAD ##1 state == cwd_pkg::CWD_RUN |=> current_osc_select == boot_osc)
    else $error("boot oscillator not loaded");
  a_fast_boot: assert property (@(posedge clk) disable iff (rst)
    state == cwd_pkg::CWD_LOAD ##1 osc_word[6:4] == 3'h0 |=> new_osc_select == 3'h6)
    else $error("code 000 did not select 110");
  a_debug_level: assert property (@(posedge clk) disable iff (rst)
    state == cwd_pkg::CWD_RUN ##1 1'b1 |-> debugger_en == !$past(sup_word[13]))
    else $error("debugger enable wrong");
  a_lock_once: assert property (@(posedge clk) disable iff (rst)
    sup_word[11] && lock_used && state == cwd_pkg::CWD_RUN |=> pin_remap_locked == $past(pin_remap_locked))
    else $error("one-way lock changed after use");
  a_words_held: assert property (@(posedge clk) disable iff (rst)
    state == cwd_pkg::CWD_RUN |=> $stable(osc_word) && $stable(sup_word))
    else $error("configuration words changed without reset");
endmodule

//--- tb/test_config_word_decode.sv
// testbench for the configuration word decoder: a table of word pairs, then bus cases
// assumes cwd_top with an AXI4-Lite slave, a 100 MHz clock and a synchronous reset
`timescale 1ns/1ps
module test_config_word_decode;
  typedef struct packed {
    logic [15:0] o;
    logic [15:0] s;
    logic lv;
    logic sl;
    logic [15:0] e;
  } cwd_row_t;
  logic clk, rst, low_voltage_program, stack_fault, sleep_mode;
  logic [15:0] nvm_osc_word, nvm_sup_word, got;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_data, h;
  logic [3:0] s_axi_wstrb, new_divider_select;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, fail_safe_monitor_en, pll_en;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [2:0] current_osc_select, new_osc_select, ext_osc_mode;
  logic osc_output_pin, osc_output_pin_oe, extended_instr_en, debugger_en, stack_reset_req;
  logic pin_remap_locked, zero_cross_en, brownout_en, low_power_brownout_en, powerup_timer_en;
  logic master_clear_en, ext_osc_en;
  logic [3:0] fast_osc_freq_select;
  int fails, checks;
  cwd_row_t rows [7];
  cwd_top uut (.clk, .rst, .nvm_osc_word, .nvm_sup_word, .low_voltage_program, .stack_fault,
    .sleep_mode, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .fail_safe_monitor_en, .current_osc_select, .new_osc_select, .new_divider_select,
    .fast_osc_freq_select, .pll_en, .ext_osc_mode, .ext_osc_en, .osc_output_pin,
    .osc_output_pin_oe, .extended_instr_en, .debugger_en, .stack_reset_req, .pin_remap_locked,
    .zero_cross_en, .brownout_en, .low_power_brownout_en, .powerup_timer_en, .master_clear_en);
  // decoded controls packed in table order
  assign got = {fail_safe_monitor_en, current_osc_select, ext_osc_mode, osc_output_pin_oe,
    extended_instr_en, debugger_en, zero_cross_en, brownout_en, low_power_brownout_en,
    powerup_timer_en, master_clear_en, pll_en};
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // counts and verdict
  task finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // compare one result, count it, report a mismatch
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bus write: both channels offered together, each released once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk("write answer", 32'h0, {31'h0, n == 50});
    if (n == 50) finish_test;
  endtask
  // bus read, held until the answer is sampled
  task rd(input logic [7:0] a);
    int n;
    @(posedge clk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd_data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk("read answer", 32'h0, {31'h0, n == 50});
    if (n == 50) finish_test;
  endtask
  // key pair, then the lock write
  task unl(input logic [31:0] d);
    wr(8'h18, 32'h55);
    wr(8'h18, 32'hAA);
    wr(8'h0C, d);
  endtask
  // present words and straps, reset for four cycles, let the decode settle
  task load(input cwd_row_t r);
    @(posedge clk);
    {nvm_osc_word, nvm_sup_word, low_voltage_program, sleep_mode} <= r[49:16];
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // main sequence: table rows, then hand-written cases
  initial begin
    {rst, low_voltage_program, stack_fault, sleep_mode, fails, checks} = '0;
    {nvm_osc_word, nvm_sup_word, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    rows[0] = {16'h3977, 16'hBF63, 1'b0, 1'b0, 16'hFE02};
    rows[1] = {16'h0006, 16'h00C0, 1'b0, 1'b1, 16'h6DFC};
    rows[2] = {16'h2022, 16'hA4A2, 1'b1, 1'b1, 16'hA403};
    rows[3] = {16'h0151, 16'h0080, 1'b0, 1'b0, 16'h52FC};
    rows[4] = {16'h0040, 16'hFF3F, 1'b0, 1'b0, 16'h4002};
    rows[5] = {16'h0065, 16'h00C0, 1'b1, 1'b1, 16'h6BFE};
    rows[6] = {16'h0074, 16'hBF63, 1'b0, 1'b0, 16'h7902};
    for (int i = 0; i < 7; i++) begin
      load(rows[i]);
      chk("controls", {16'h0, rows[i].e}, {16'h0, got});
      $display("row %0d done", i);
    end
    // permit clear, one-way off, stack reset off
    load(rows[1]);
    wr(8'h08, 32'h25);
    chk("new_osc_select", 32'h6, {29'h0, new_osc_select});
    chk("fast_osc_freq_select", 32'h8, {28'h0, fast_osc_freq_select});
    chk("new_divider_select", 32'h0, {28'h0, new_divider_select});
    chk("ext_osc_en", 32'h1, {31'h0, ext_osc_en});
    rd(8'h14);
    chk("status", 32'h46, rd_data);
    h = 32'h0;
    repeat (8) begin
      @(posedge clk);
      h = h + {31'h0, osc_output_pin};
    end
    chk("clock-out highs", 32'h2, h);
    stack_fault <= 1'b1;
    repeat (5) @(posedge clk);
    chk("stack_reset_req", 32'h0, {31'h0, stack_reset_req});
    stack_fault <= 1'b0;
    wr(8'h0C, 32'h1);
    chk("pin_remap_locked", 32'h0, {31'h0, pin_remap_locked});
    unl(32'h1);
    chk("pin_remap_locked", 32'h1, {31'h0, pin_remap_locked});
    unl(32'h0);
    chk("pin_remap_locked", 32'h0, {31'h0, pin_remap_locked});
    $display("test permit clear done");
    // permit set, one-way on, words changed after load
    load(rows[0]);
    {nvm_osc_word, nvm_sup_word} <= 32'h0;
    repeat (4) @(posedge clk);
    chk("held controls", 32'hFE02, {16'h0, got});
    rd(8'h00);
    chk("oscillator word", 32'h3977, rd_data);
    rd(8'h40);
    chk("unmapped read", 32'h2, {rd_data[29:0], resp});
    stack_fault <= 1'b1;
    repeat (5) @(posedge clk);
    chk("stack_reset_req", 32'h1, {31'h0, stack_reset_req});
    stack_fault <= 1'b0;
    wr(8'h08, 32'h25);
    chk("new selection", 32'h25, {24'h0, new_divider_select, 1'b0, new_osc_select});
    wr(8'h10, 32'h3);
    // decoded enables follow the software bits one cycle later
    @(posedge clk);
    chk("software enables", 32'h3, {30'h0, zero_cross_en, brownout_en});
    unl(32'h1);
    chk("pin_remap_locked", 32'h1, {31'h0, pin_remap_locked});
    unl(32'h0);
    chk("pin_remap_locked", 32'h1, {31'h0, pin_remap_locked});
    $display("test permit set done");
    // reserved reset and mode codes are flagged, external oscillator stays off
    load({16'h0013, 16'hBF63, 1'b0, 1'b0, 16'h0000});
    chk("ext_osc_en", 32'h0, {31'h0, ext_osc_en});
    rd(8'h14);
    chk("reserved code", 32'h1, {31'h0, rd_data[9]});
    $display("test reserved codes done");
    finish_test;
  end
endmodule
